// File: hw/ata_sec_pkg.sv
// Constants, register map and carrier types for the security command logic.
// Assumes a single 250 MHz clock and an ATA host controller front end.
package ata_sec_pkg;
	localparam logic [7:0] OP_SET_PW = 8'hF1;
	localparam logic [7:0] OP_UNLOCK = 8'hF2;
	localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
	localparam logic [7:0] OP_ERASE = 8'hF4;
	localparam logic [7:0] OP_FREEZE = 8'hF5;
	localparam logic [7:0] LAST_WORD = 8'hFF;
	localparam logic [7:0] PW_FIRST = 8'h01;
	localparam logic [7:0] PW_LAST = 8'h10;
	localparam int ID_BIT = 0;
	localparam int LEVEL_BIT = 8;
	localparam logic [2:0] ATTEMPTS_INIT = 3'h5;
	localparam logic [7:0] STAT_OK = 8'h50;
	localparam logic [7:0] STAT_ABORT = 8'h51;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h0C;
	localparam logic CTRL_SEC_RESET = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_EXPIRED = 2;
	localparam int IRQ_W = 3;

	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} word_t;

	typedef struct packed {
		logic valid;
		logic abort;
		logic [7:0] status;
		logic [7:0] error;
	} cpl_t;

	typedef logic [15:0][15:0] pw_t;

	typedef enum logic {ST_IDLE, ST_DATA} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [7:0] op;
		logic [7:0] cnt;
		logic ident;
		logic level_req;
		logic mism;
		logic prep_seen;
		logic prep_ok;
		pw_t user_pw;
		pw_t master_pw;
		logic lock_en;
		logic level_max;
		logic locked;
		logic frozen;
		logic [2:0] tries;
		logic sec_en;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic cmd_ready;
		logic word_ready;
		cpl_t cpl;
		logic sc_zero;
		logic wear;
		logic erase_go;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;
endpackage : ata_sec_pkg

// File: hw/ata_sec_cmd.sv
// Security command logic: set password, unlock, erase unit, freeze lock.
// Assumes the ATA host controller hands over opcodes and 256 payload words.
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Opcodes F1h, F2h, F4h are taken, each followed by one 256-word sector.
// - Erase unit aborts when the supplied password differs from the stored one.
// - Erase unit aborts unless the command just before was erase prepare.
// - Erase sector: word 0 bit 0 picks user/master, words 1-16 the password.
// - Freeze lock sets frozen; frozen rejects set password, unlock and erase.
// - Frozen clears only at power-on or hardware reset.
// - Freeze lock while frozen completes normally and stays frozen.
// - A completed freeze lock loads zero into the sector count register.
// - With security unsupported, freeze lock runs as a wear-level command.
// - Set password sector: bit 0 user/master, bit 8 high/maximum, words 1-16.
// - User at high: store, lock from next hardware reset, user or master unlocks.
// - User at maximum: store, lock from next hardware reset, only user unlocks.
// - Master: store master password, lock enable and level unchanged.
// - Unlock with master compares at high level, is rejected at maximum.
// - Unlock with user compares against the stored user password.
// - Counter starts at five; failed unlock while locked aborts and decrements.
// - At zero, every unlock and erase unit aborts until a reset.
// - Unlock while already unlocked leaves the counter unchanged.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module ata_sec_cmd (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic hw_reset_i,
	input wire ata_sec_pkg::cmd_t cmd_i,
	output logic cmd_ready_o,
	input wire ata_sec_pkg::word_t word_i,
	output logic word_ready_o,
	output ata_sec_pkg::cpl_t cpl_o,
	output logic sc_zero_o,
	output logic wear_level_o,
	output logic erase_start_o,
	output logic irq_o,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [ata_sec_pkg::ADDR_W-1:0] awaddr_i,
	input wire logic wvalid_i,
	output logic wready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	output logic bvalid_o,
	input wire logic bready_i,
	output logic [1:0] bresp_o,
	input wire logic arvalid_i,
	output logic arready_o,
	input wire logic [ata_sec_pkg::ADDR_W-1:0] araddr_i,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o
);
	import ata_sec_pkg::*;

	state_t st;
	state_t next_st;
	logic cmd_take;
	logic fin;
	logic abort;
	logic [3:0] idx;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.cpl.valid = 1'b0;
		next_st.sc_zero = 1'b0;
		next_st.wear = 1'b0;
		next_st.erase_go = 1'b0;
		next_st.awready = 1'b0;
		next_st.wready = 1'b0;
		next_st.arready = 1'b0;
		cmd_take = cmd_i.valid && st.cmd_ready;
		fin = st.phase == ST_DATA && word_i.valid && st.cnt == LAST_WORD;
		abort = 1'b0;
		idx = 4'(st.cnt - PW_FIRST);
		irq_set = '0;
		irq_clr = '0;
		unique case (st.phase)
			ST_IDLE: begin
				if (cmd_take) begin
					// prep must be the previous command
					next_st.prep_seen = cmd_i.opcode == OP_ERASE_PREP;
					next_st.prep_ok = st.prep_seen;
					if (cmd_i.opcode == OP_SET_PW || cmd_i.opcode == OP_UNLOCK ||
						cmd_i.opcode == OP_ERASE) begin
						next_st.phase = ST_DATA;
						next_st.op = cmd_i.opcode;
						next_st.cnt = '0;
						next_st.mism = 1'b0;
						next_st.cmd_ready = 1'b0;
						next_st.word_ready = 1'b1;
					end else if (cmd_i.opcode == OP_FREEZE) begin
						next_st.cpl.valid = 1'b1;
						if (st.sec_en) begin
							next_st.frozen = 1'b1;
							next_st.sc_zero = 1'b1;
						end else begin
							next_st.wear = 1'b1;
						end
					end
				end
			end
			ST_DATA: begin
				if (word_i.valid) begin
					next_st.cnt = st.cnt + 8'h01;
					if (st.cnt == '0) begin
						next_st.ident = word_i.data[ID_BIT];
						next_st.level_req = word_i.data[LEVEL_BIT];
					end else if (st.cnt <= PW_LAST) begin
						// Set password writes in place; frozen leaves both untouched
						if (st.op == OP_SET_PW) begin
							if (!st.frozen && st.ident) begin
								next_st.master_pw[idx] = word_i.data;
							end else if (!st.frozen) begin
								next_st.user_pw[idx] = word_i.data;
							end
						end else if (st.ident) begin
							next_st.mism = st.mism || word_i.data != st.master_pw[idx];
						end else begin
							next_st.mism = st.mism || word_i.data != st.user_pw[idx];
						end
					end
				end
				if (fin) begin
					next_st.phase = ST_IDLE;
					next_st.cmd_ready = 1'b1;
					next_st.word_ready = 1'b0;
					next_st.cpl.valid = 1'b1;
					unique case (st.op)
						OP_SET_PW: begin
							abort = st.frozen;
							if (!st.frozen && !st.ident) begin
								next_st.lock_en = 1'b1;
								next_st.level_max = st.level_req;
							end
						end
						OP_UNLOCK: begin
							abort = st.frozen || st.tries == '0 ||
								(st.ident && st.level_max) || st.mism;
							if (!st.frozen && st.tries != '0 && !(st.ident && st.level_max)) begin
								if (st.mism && st.locked) begin
									next_st.tries = st.tries - 3'h1;
								end else if (!st.mism) begin
									next_st.locked = 1'b0;
								end
							end
						end
						default: begin
							abort = st.frozen || st.tries == '0 || !st.prep_ok || st.mism;
							next_st.erase_go = !abort;
						end
					endcase
				end
			end
		endcase
		next_st.cpl.abort = abort;
		next_st.cpl.status = abort ? STAT_ABORT : STAT_OK;
		next_st.cpl.error = abort ? ERR_ABORT : ERR_NONE;
		// hardware reset ends frozen and reloads the counter
		if (hw_reset_i) begin
			next_st.frozen = 1'b0;
			next_st.tries = ATTEMPTS_INIT;
			next_st.locked = st.lock_en;
			next_st.phase = ST_IDLE;
			next_st.cmd_ready = 1'b1;
			next_st.word_ready = 1'b0;
			next_st.prep_seen = 1'b0;
			// Cut phase ends silently
			next_st.cpl.valid = 1'b0;
			next_st.erase_go = 1'b0;
			next_st.sc_zero = 1'b0;
			next_st.wear = 1'b0;
		end
		////////////////////////////////////////////////////////////////////////
		// Register bus: address and data are taken together, answer follows
		if (awvalid_i && wvalid_i && !st.awready && !st.bvalid) begin
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (st.awready) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			unique case (awaddr_i)
				REG_CTRL: begin
					if (wstrb_i[0]) begin
						next_st.sec_en = wdata_i[0];
					end
				end
				REG_IRQ_STAT: begin
					if (wstrb_i[0]) begin
						irq_clr = wdata_i[IRQ_W-1:0];
					end
				end
				REG_IRQ_MASK: begin
					if (wstrb_i[0]) begin
						next_st.irq_mask = wdata_i[IRQ_W-1:0];
					end
				end
				REG_STATUS: begin
				end
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end else if (st.bvalid && bready_i) begin
			next_st.bvalid = 1'b0;
		end
		if (arvalid_i && !st.arready && !st.rvalid) begin
			next_st.arready = 1'b1;
		end
		if (st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			unique case (araddr_i)
				REG_CTRL: next_st.rdata[0] = st.sec_en;
				REG_STATUS: next_st.rdata[7:0] = {st.tries == '0, st.tries, st.level_max,
					st.lock_en, st.frozen, st.locked};
				REG_IRQ_STAT: next_st.rdata[IRQ_W-1:0] = st.irq_stat;
				REG_IRQ_MASK: next_st.rdata[IRQ_W-1:0] = st.irq_mask;
				default: next_st.rresp = RESP_SLVERR;
			endcase
		end else if (st.rvalid && rready_i) begin
			next_st.rvalid = 1'b0;
		end
		// Sticky events: a set in the clearing cycle wins
		irq_set[IRQ_DONE] = next_st.cpl.valid;
		irq_set[IRQ_ABORT] = next_st.cpl.valid && abort;
		irq_set[IRQ_EXPIRED] = next_st.tries == '0 && st.tries != '0;
		next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
	end

	// Passwords only clear at power-on; non-volatile keeping is outside.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.cmd_ready <= 1'b1;
			st.tries <= ATTEMPTS_INIT;
			st.sec_en <= CTRL_SEC_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign cmd_ready_o = st.cmd_ready;
	assign word_ready_o = st.word_ready;
	assign cpl_o = st.cpl;
	assign sc_zero_o = st.sc_zero;
	assign wear_level_o = st.wear;
	assign erase_start_o = st.erase_go;
	assign irq_o = st.irq;
	assign awready_o = st.awready;
	assign wready_o = st.wready;
	assign bvalid_o = st.bvalid;
	assign bresp_o = st.bresp;
	assign arready_o = st.arready;
	assign rvalid_o = st.rvalid;
	assign rdata_o = st.rdata;
	assign rresp_o = st.rresp;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_freeze_taken;
		cmd_take && cmd_i.opcode == OP_FREEZE && !hw_reset_i;
	endsequence

	sequence s_fin_clean;
		fin && !hw_reset_i;
	endsequence

	AST_PAYLOAD_CMD: assert property (
		cmd_take && !hw_reset_i && (cmd_i.opcode == OP_UNLOCK || cmd_i.opcode == OP_SET_PW)
		|=> st.phase == ST_DATA && word_ready_o && !cmd_ready_o ##0 (word_ready_o [*8]))
		else $error("payload command did not open a data phase");

	AST_ERASE_MISMATCH: assert property (
		s_fin_clean ##0 (st.op == OP_ERASE && st.mism) |=> cpl_o.valid && cpl_o.abort && !erase_start_o)
		else $error("erase with wrong password not aborted");

	AST_ERASE_NO_PREP: assert property (
		s_fin_clean ##0 (st.op == OP_ERASE && !st.prep_ok) |=> cpl_o.abort)
		else $error("erase without prepare not aborted");

	AST_FREEZE_SETS: assert property (
		s_freeze_taken ##0 st.sec_en |=> st.frozen && cpl_o.valid && !cpl_o.abort && sc_zero_o)
		else $error("freeze lock did not complete frozen");

	AST_FROZEN_REJECTS: assert property (
		s_fin_clean ##0 st.frozen |=> cpl_o.valid && cpl_o.abort && cpl_o.error == ERR_ABORT)
		else $error("frozen device accepted a security command");

	AST_FROZEN_HOLDS: assert property (
		st.frozen && !hw_reset_i |=> st.frozen)
		else $error("frozen state left without reset");

	AST_WEAR_LEVEL: assert property (
		s_freeze_taken ##0 !st.sec_en |=> wear_level_o && !sc_zero_o && $stable(st.frozen))
		else $error("unsupported freeze lock not run as wear level");

	AST_MASTER_AT_MAX: assert property (
		s_fin_clean ##0 (st.op == OP_UNLOCK && st.ident && st.level_max)
		|=> cpl_o.abort && $stable(st.locked) && $stable(st.tries))
		else $error("master unlock at maximum level not rejected");

	AST_COUNT_DOWN: assert property (
		s_fin_clean ##0 (st.op == OP_UNLOCK && st.mism && st.locked && !st.frozen &&
		st.tries != '0 && !(st.ident && st.level_max)) |=> st.tries == $past(st.tries) - 3'h1)
		else $error("failed unlock did not decrement the counter");

	AST_EXHAUSTED: assert property (
		s_fin_clean ##0 (st.tries == '0 && st.op != OP_SET_PW) |=> cpl_o.abort ##1 st.tries == '0)
		else $error("command accepted with counter at zero");

	AST_UNLOCKED_KEEPS: assert property (
		s_fin_clean ##0 (st.op == OP_UNLOCK && !st.locked) |=> $stable(st.tries))
		else $error("unlock while unlocked changed the counter");

	AST_ABORT_STATUS: assert property (
		cpl_o.valid |-> (cpl_o.abort ? cpl_o.status == STAT_ABORT : cpl_o.status == STAT_OK))
		else $error("completion status disagrees with abort");

	AST_USER_LOCK_LEVEL: assert property (
		s_fin_clean ##0 (st.op == OP_SET_PW && !st.frozen && !st.ident)
		|=> st.lock_en && st.level_max == $past(st.level_req))
		else $error("user password did not set lock and level");

	AST_MASTER_KEEPS: assert property (
		s_fin_clean ##0 (st.op == OP_SET_PW && st.ident)
		|=> $stable(st.lock_en) && $stable(st.level_max))
		else $error("master password changed lock or level");

	AST_HW_RESET: assert property (
		hw_reset_i |=> !st.frozen && st.tries == ATTEMPTS_INIT && cmd_ready_o && !cpl_o.valid)
		else $error("hardware reset did not clear frozen and counter");
endmodule : ata_sec_cmd

// File: testbench/ata_host_model.sv
// Host controller model: issues security opcodes and their payload sectors.
// Assumes the block clock and the design's command, payload and completion ports.
module ata_host_model (
	input wire logic mclk_i,
	input wire logic cmd_ready_i,
	input wire logic word_ready_i,
	input wire ata_sec_pkg::cpl_t cpl_i,
	input wire logic [2:0] side_i,
	output ata_sec_pkg::cmd_t cmd_o,
	output ata_sec_pkg::word_t word_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ata_sec_pkg::*;
	initial begin
		cmd_o = '0;
		word_o = '0;
	end
	////////////////////////////////////////////////////////////////////////////
	// opcode, then sector
	task automatic issue(input logic [7:0] op, input logic [15:0] ctl, input logic [15:0] pw,
		output cpl_t cpl, output logic [2:0] side);
		int n;
		int t;
		cmd_o <= '{valid: 1'h1, opcode: op};
		do @(posedge mclk_i); while (cmd_ready_i !== 1'h1);
		// Released lines show the inverse, never the last value
		cmd_o <= '{valid: 1'h0, opcode: ~op};
		if (op == OP_SET_PW || op == OP_UNLOCK || op == OP_ERASE) begin
			for (n = 0; n < 256; n++) begin
				word_o <= '{valid: 1'h1, data: (n == 0) ? ctl : (n <= 16) ? pw + 16'(n) : ~pw};
				do @(posedge mclk_i); while (word_ready_i !== 1'h1);
			end
			word_o <= '{valid: 1'h0, data: ~word_o.data};
		end
		cpl = '0;
		side = '0;
		t = 0;
		if (op != OP_ERASE_PREP) begin
			while (cpl_i.valid !== 1'h1 && t < 20) begin
				@(posedge mclk_i);
				t++;
			end
			cpl = cpl_i;
			side = side_i;
		end else begin
			@(posedge mclk_i);
		end
	endtask : issue
endmodule : ata_host_model

// File: testbench/ata_security_command_logic_tb.sv
// Self-checking bench for the security command logic.
// Assumes the host model file and the design package are compiled first.
module ata_security_command_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ata_sec_pkg::*;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic hw_reset = 1'h0;
	cmd_t cmd;
	word_t word;
	cpl_t cpl;
	cpl_t c;
	logic cmd_ready, word_ready, sc_zero, wear, erase_go, irq;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp, r;
	logic [2:0] s;
	logic [15:0] pu, pm, pu2;
	int fail_count = 0;
	int cmp_count = 0;
	int i;
	integer seed = 32'h3919;
	always #2 mclk = ~mclk;
	ata_sec_cmd u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .hw_reset_i(hw_reset), .cmd_i(cmd),
		.cmd_ready_o(cmd_ready), .word_i(word), .word_ready_o(word_ready), .cpl_o(cpl),
		.sc_zero_o(sc_zero), .wear_level_o(wear), .erase_start_o(erase_go), .irq_o(irq),
		.awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
		.wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
		.bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
		.araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
		.rresp_o(rresp));
	ata_host_model u_host (.mclk_i(mclk), .cmd_ready_i(cmd_ready), .word_ready_i(word_ready),
		.cpl_i(cpl), .side_i({sc_zero, wear, erase_go}), .cmd_o(cmd), .word_o(word));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge mclk);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= 1'h1;
		do begin @(posedge mclk); t++; end while (!(awready === 1'h1 && wready === 1'h1) && t < 50);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		while (bvalid !== 1'h1 && t < 50) begin @(posedge mclk); t++; end
		r = bresp;
		bready <= 1'h0;
		chk("write response", 32'(RESP_OKAY), {29'h0, t >= 50, r});
	endtask : axw
	task automatic axr(input logic [4:0] a);
		int t = 0;
		@(posedge mclk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		do begin @(posedge mclk); t++; end while (arready !== 1'h1 && t < 50);
		arvalid <= 1'h0;
		while (rvalid !== 1'h1 && t < 50) begin @(posedge mclk); t++; end
		v = rdata;
		r = rresp;
		rready <= 1'h0;
		chk("read handshake", 32'h0, {31'h0, t >= 50});
	endtask : axr
	function automatic logic [31:0] st(input logic lk, fz, le, lm, input logic [2:0] tr);
		return {24'h0, tr == 3'h0, tr, lm, le, fz, lk};
	endfunction : st
	task automatic sts(input logic [31:0] e);
		axr(REG_STATUS);
		chk("status", e, v);
	endtask : sts
	task automatic run(input logic [7:0] op, input logic [15:0] ctl, input logic [15:0] pw,
		input logic ab);
		u_host.issue(op, ctl, pw, c, s);
		chk("completion", {ab ? STAT_ABORT : STAT_OK, ab ? ERR_ABORT : ERR_NONE, 7'h0, 1'h1, 7'h0, ab},
			{c.status, c.error, 7'h0, c.valid, 7'h0, c.abort});
	endtask : run
	task automatic ers(input logic [15:0] ctl, input logic [15:0] pw, input logic ab);
		u_host.issue(OP_ERASE_PREP, 16'h0, 16'h0, c, s);
		run(OP_ERASE, ctl, pw, ab);
		chk("erase start", {31'h0, ~ab}, 32'(s[0]));
	endtask : ers
	task automatic hwr;
		hw_reset <= 1'h1;
		@(posedge mclk);
		hw_reset <= 1'h0;
		@(posedge mclk);
	endtask : hwr
	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done
	////////////////////////////////////////////////////////////////////////////
	// Watchdog: a full run takes about 6k cycles
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		pu = 16'($random(seed));
		pm = 16'($random(seed));
		pu2 = pu ^ 16'h8001;
		repeat (10) @(posedge mclk);
		rst_n <= 1'h1;
		axr(REG_CTRL);
		chk("ctrl", 32'h1, v);
		sts(st(0, 0, 0, 0, 5));
		axr(5'h10);
		chk("unmapped", 32'(RESP_SLVERR), 32'(r));
		done("reset");
		run(OP_SET_PW, 16'h0000, pu, 1'h0);
		sts(st(0, 0, 1, 0, 5));
		run(OP_ERASE, 16'h0, pu, 1'h1);
		run(OP_SET_PW, 16'h0101, pm, 1'h0);
		sts(st(0, 0, 1, 0, 5));
		ers(16'h0, pu, 1'h0);
		ers(16'h1, pm, 1'h0);
		ers(16'h0, pm, 1'h1);
		u_host.issue(OP_ERASE_PREP, 16'h0, 16'h0, c, s);
		run(OP_UNLOCK, 16'h0, ~pu, 1'h1);
		run(OP_ERASE, 16'h0, pu, 1'h1);
		axr(REG_IRQ_STAT);
		chk("irq stat", 32'h3, v);
		chk("irq masked", 32'h0, 32'(irq));
		axw(REG_IRQ_MASK, 32'h7);
		repeat (2) @(posedge mclk);
		chk("irq on", 32'h1, 32'(irq));
		axw(REG_IRQ_STAT, 32'h7);
		repeat (2) @(posedge mclk);
		chk("irq cleared", 32'h0, 32'(irq));
		sts(st(0, 0, 1, 0, 5));
		done("passwords");
		hwr();
		sts(st(1, 0, 1, 0, 5));
		run(OP_UNLOCK, 16'h1, pm, 1'h0);
		sts(st(0, 0, 1, 0, 5));
		hwr();
		run(OP_UNLOCK, 16'h0, pu, 1'h0);
		run(OP_SET_PW, 16'h0100, pu2, 1'h0);
		hwr();
		run(OP_UNLOCK, 16'h1, pm, 1'h1);
		sts(st(1, 0, 1, 1, 5));
		for (i = 1; i <= 5; i++) begin
			run(OP_UNLOCK, 16'h0, pu2 ^ (16'($random(seed)) | 16'h1), 1'h1);
			sts(st(1, 0, 1, 1, 3'(5 - i)));
		end
		run(OP_UNLOCK, 16'h0, pu2, 1'h1);
		ers(16'h0, pu2, 1'h1);
		axr(REG_IRQ_STAT);
		chk("expiry", 32'h4, v & 32'h4);
		chk("irq expiry", 32'h1, 32'(irq));
		done("counter");
		hwr();
		run(OP_UNLOCK, 16'h0, pu2, 1'h0);
		run(OP_FREEZE, 16'h0, 16'h0, 1'h0);
		chk("freeze side", 32'h2, 32'(s[2:1]));
		run(OP_FREEZE, 16'h0, 16'h0, 1'h0);
		chk("refreeze side", 32'h2, 32'(s[2:1]));
		run(OP_SET_PW, 16'h0, pu, 1'h1);
		run(OP_UNLOCK, 16'h0, pu, 1'h1);
		ers(16'h0, pu2, 1'h1);
		sts(st(0, 1, 1, 1, 5));
		hwr();
		sts(st(1, 0, 1, 1, 5));
		axw(REG_CTRL, 32'h0);
		run(OP_FREEZE, 16'h0, 16'h0, 1'h0);
		chk("wear", 32'h1, 32'(s[1]));
		sts(st(1, 0, 1, 1, 5));
		done("freeze");
		tally_and_finish();
	end
endmodule : ata_security_command_logic_tb
